// ==== logic/sfc_front_end.sv ====
`timescale 1ns/100ps
module sfc_front_end
  import sfc_pkg::*;
#(
  parameter int         SECTOR_CLEAR_CYCLES_P = sfc_pkg::SECTOR_CLEAR_CYCLES,
  parameter int         STATUS_WRITE_CYCLES_P = sfc_pkg::STATUS_WRITE_CYCLES,
  parameter int         ADDR_WIDTH            = 17,
  parameter logic [7:0] MAKER_CODE            = 8'h5a,  // arbitrary value
  parameter logic [7:0] PART_CODE             = 8'ha5   // arbitrary value
) (
  input  wire logic                  i_clock,
  input  wire logic                  i_rst,
  input  wire logic                  i_sck,
  input  wire logic                  i_cs_n,
  input  wire logic                  i_si,
  input  wire logic                  i_hold_n,
  input  wire logic                  i_wp_n,
  input  wire logic [7:0]            i_array_data,
  output logic                       o_so,
  output logic                       o_so_oe,
  output logic [ADDR_WIDTH-1:0]      o_array_addr,
  output logic                       o_cycle_busy
);
  import sfc_pkg::*;

  if (ADDR_WIDTH < SECTOR_MSB + 1 || ADDR_WIDTH > 8 * ADDR_BYTES) begin : g_bad_addr
    $error("ADDR_WIDTH must lie between 17 and 24");
  end
  if (SECTOR_CLEAR_CYCLES_P < 1 || STATUS_WRITE_CYCLES_P < 1) begin : g_bad_time
    $error("cycle counts must be at least one");
  end

  function automatic logic op_match(input logic [7:0] op, input logic [7:0] ref_op);
    op_match = {op[7:4], op[2:0]} == {ref_op[7:4], ref_op[2:0]};
  endfunction : op_match

  function automatic logic sector_locked(input logic [1:0] prot, input logic [1:0] sector);
    case (prot)
      2'h0:    sector_locked = 1'b0;
      2'h1:    sector_locked = sector == 2'h3;
      2'h2:    sector_locked = sector[1];
      default: sector_locked = 1'b1;
    endcase
  endfunction : sector_locked

  // ---------------- link side, serial clock domain ----------------
  sfc_frame_t        frame_state;
  sfc_frame_t        next_frame_state;
  logic [2:0]        bit_cnt;
  logic [6:0]        rx_sh;
  logic [7:0]        op;
  logic [1:0]        addr_cnt;
  logic [15:0]       addr_hi;
  logic              prog_ok;
  logic [8:0]        prog_bytes;
  logic              id_second;
  logic [6:0]        tx_sh;
  logic              oe_q;

  logic              wel;
  logic [1:0]        prot;
  logic              pin_en;
  logic              arm_tog;
  sfc_kind_t         arm_kind;
  logic              arm_pin_en;
  logic [8:0]        arm_count;
  logic [2:0]        pend_bits;
  logic              done_seen;
  logic              done_sync;

  // ---------------- system clock domain ----------------
  sfc_sys_t          sys_state;
  logic              cs_s;
  logic              wp_s;
  logic              arm_s;
  logic              arm_seen;
  logic              wp_fell;
  logic              done_tog;
  logic              result_ok;
  logic              timer_start;
  logic              timer_done;

  // the frame is held in reset while deselected
  wire        frame_rst  = i_rst | i_cs_n;
  wire        shift_en   = i_hold_n;
  wire [7:0]  rx_byte    = {rx_sh, i_si};
  wire [7:0]  opc        = (frame_state == FR_OPCODE) ? rx_byte : op;
  wire        byte_end   = shift_en && bit_cnt == 3'h7 && frame_state != FR_IGNORE;
  wire        op_end     = byte_end && frame_state == FR_OPCODE;
  wire        addr_end   = byte_end && frame_state == FR_ADDRESS && addr_cnt == 2'(ADDR_BYTES - 1);
  wire        data_end   = byte_end && frame_state == FR_DATA_IN;
  wire        send_end   = byte_end && frame_state == FR_SEND;
  wire [23:0] full_addr  = {addr_hi, rx_byte};
  wire        busy_now   = arm_tog != done_sync;
  wire        done_new   = done_sync != done_seen;

  wire is_set_write_latch_cmd   = op_match(opc, SET_WRITE_LATCH_CMD);
  wire is_clear_write_latch_cmd   = op_match(opc, CLEAR_WRITE_LATCH_CMD);
  wire is_sread  = op_match(opc, STATUS_READ_CMD);
  wire is_swrite = op_match(opc, STATUS_WRITE_CMD);
  wire is_read   = op_match(opc, ARRAY_READ_CMD);
  wire is_prog   = op_match(opc, ARRAY_PROGRAM_CMD);
  wire is_sect   = op_match(opc, SECTOR_ERASE_CMD);
  wire is_chip   = op_match(opc, CHIP_ERASE_CMD);
  wire is_id     = op_match(opc, IDENTITY_READ_CMD);

  wire target_locked = sector_locked(prot, full_addr[SECTOR_MSB:SECTOR_LSB]);
  wire arm_chip  = op_end && is_chip && !busy_now && wel && prot == 2'h0;
  wire arm_sect  = addr_end && is_sect && wel && !target_locked;
  wire prog_byte = data_end && is_prog && prog_ok;
  wire arm_prog  = prog_byte && prog_bytes == 9'h0;
  wire arm_stat  = data_end && is_swrite && wel;
  wire arm_fire  = arm_chip | arm_sect | arm_prog | arm_stat;
  wire [8:0] next_prog_bytes = (prog_bytes == PAGE_BYTES) ? prog_bytes : prog_bytes + 9'h1;

  sfc_kind_t next_kind;
  assign next_kind = arm_stat ? KIND_STATUS :
                     arm_prog ? KIND_PROGRAM :
                     arm_sect ? KIND_SECTOR : KIND_CHIP;

  // status read shows all ones while a cycle runs
  wire [7:0] status_view = (arm_tog != done_seen) ? STATUS_BUSY_VALUE :
                           {pin_en, 3'h0, prot, wel, 1'b0};
  wire [7:0] id_byte     = id_second ? PART_CODE : MAKER_CODE;
  wire [7:0] tx_byte     = is_sread ? status_view : (is_id ? id_byte : i_array_data);
  wire       tx_load     = frame_state == FR_SEND && bit_cnt == 3'h0;

  always_comb begin
    next_frame_state = frame_state;
    case (frame_state)
      FR_OPCODE: begin
        if (op_end) begin
          if (busy_now && !is_sread)
            next_frame_state = FR_IGNORE;
          else if (is_sread || is_id)
            next_frame_state = FR_SEND;
          else if (is_read || is_prog || is_sect)
            next_frame_state = FR_ADDRESS;
          else if (is_swrite)
            next_frame_state = FR_DATA_IN;
          else
            next_frame_state = FR_IGNORE;
        end
      end
      FR_ADDRESS: begin
        if (addr_end)
          next_frame_state = is_read ? FR_SEND : (is_prog ? FR_DATA_IN : FR_IGNORE);
      end
      FR_DATA_IN: begin
        if (data_end && is_swrite)
          next_frame_state = FR_IGNORE;
      end
      default: next_frame_state = frame_state;
    endcase
  end

  // sampling edge; in the ignore state nothing further is taken in
  always_ff @(posedge i_sck or posedge frame_rst) begin
    if (frame_rst) begin
      frame_state <= FR_OPCODE;
      bit_cnt     <= 3'h0;
      rx_sh       <= 7'h0;
      op          <= 8'h0;
      addr_cnt    <= 2'h0;
      addr_hi     <= 16'h0;
      prog_ok     <= 1'b0;
      prog_bytes  <= 9'h0;
      id_second   <= 1'b0;
    end else if (shift_en && frame_state != FR_IGNORE) begin
      bit_cnt     <= bit_cnt + 3'h1;
      rx_sh       <= rx_byte[6:0];
      frame_state <= next_frame_state;
      if (op_end)
        op <= rx_byte;
      if (byte_end && frame_state == FR_ADDRESS) begin
        addr_cnt <= addr_cnt + 2'h1;
        addr_hi  <= full_addr[15:0];
      end
      if (addr_end)
        prog_ok <= wel && !target_locked;
      if (prog_byte)
        prog_bytes <= next_prog_bytes;
      if (send_end)
        id_second <= 1'b1;
    end
  end

  // persistent device state; only power-on reset clears it
  always_ff @(posedge i_sck or posedge i_rst) begin
    if (i_rst) begin
      wel        <= 1'b0;
      prot       <= BLOCK_PROTECT_RESET;
      pin_en     <= PIN_ENABLE_RESET;
      arm_tog    <= 1'b0;
      arm_kind   <= KIND_STATUS;
      arm_pin_en <= 1'b0;
      arm_count  <= 9'h0;
      pend_bits  <= 3'h0;
      done_seen  <= 1'b0;
    end else begin
      if (done_new) begin
        done_seen <= done_sync;
        if (result_ok && arm_kind == KIND_STATUS) begin
          pin_en <= pend_bits[2];
          prot   <= pend_bits[1:0];
          wel    <= 1'b0;
        end
        if (result_ok && arm_kind == KIND_PROGRAM)
          wel <= 1'b0;
      end
      if (op_end && !busy_now && is_set_write_latch_cmd)
        wel <= 1'b1;
      if (op_end && !busy_now && is_clear_write_latch_cmd)
        wel <= 1'b0;
      if (arm_fire) begin
        arm_tog    <= ~arm_tog;
        arm_kind   <= next_kind;
        arm_pin_en <= pin_en;
        arm_count  <= 9'h1;
      end
      if (arm_stat)
        pend_bits <= {rx_byte[PROTECT_PIN_ENABLE_BIT],
                      rx_byte[BLOCK_PROTECT_HI_BIT], rx_byte[BLOCK_PROTECT_LO_BIT]};
      if (prog_byte && !arm_prog)
        arm_count <= next_prog_bytes;
    end
  end

  // array read address; it runs on and wraps at the top of the array
  always_ff @(posedge i_sck or posedge i_rst) begin
    if (i_rst)
      o_array_addr <= '0;
    else if (addr_end && is_read)
      o_array_addr <= full_addr[ADDR_WIDTH-1:0];
    else if (send_end && is_read && shift_en)
      o_array_addr <= o_array_addr + 1'b1;
  end

  // launching edge; a paused frame keeps its place in the byte
  always_ff @(negedge i_sck or posedge frame_rst) begin
    if (frame_rst) begin
      o_so  <= 1'b0;
      tx_sh <= 7'h0;
      oe_q  <= 1'b0;
    end else begin
      oe_q <= frame_state == FR_SEND;
      if (shift_en && tx_load) begin
        o_so  <= tx_byte[7];
        tx_sh <= tx_byte[6:0];
      end else if (shift_en) begin
        o_so  <= tx_sh[6];
        tx_sh <= {tx_sh[5:0], 1'b0};
      end
    end
  end

  // pause must reach the pin at once, so the enable is gated after its flop
  assign o_so_oe = oe_q & i_hold_n;

  sfc_sync #(
    .WIDTH   (1),
    .RST_VAL (1'b0)
  ) u_done_sync (
    .i_clock (i_sck),
    .i_rst   (i_rst),
    .i_async (done_tog),
    .o_sync  (done_sync)
  );

  sfc_sync #(
    .WIDTH   (3),
    .RST_VAL (3'b110)
  ) u_pin_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async ({i_cs_n, i_wp_n, arm_tog}),
    .o_sync  ({cs_s, wp_s, arm_s})
  );

  // arm_kind, arm_count and arm_pin_en are stable once chip select is high
  wire [31:0] run_cycles =
      (arm_kind == KIND_STATUS)  ? 32'(STATUS_WRITE_CYCLES_P) :
      (arm_kind == KIND_PROGRAM) ? 32'(arm_count) * 32'(BYTE_PROGRAM_CYCLES) :
      (arm_kind == KIND_SECTOR)  ? 32'(SECTOR_CLEAR_CYCLES_P) :
                                   32'(CHIP_SECTORS) * 32'(SECTOR_CLEAR_CYCLES_P);
  wire stat_refused = arm_kind == KIND_STATUS && arm_pin_en && (wp_fell || !wp_s);

  assign timer_start = sys_state == SYS_ARMED && cs_s && !stat_refused;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sys_state    <= SYS_IDLE;
      arm_seen     <= 1'b0;
      wp_fell      <= 1'b0;
      done_tog     <= 1'b0;
      result_ok    <= 1'b0;
      o_cycle_busy <= 1'b0;
    end else begin
      case (sys_state)
        SYS_IDLE: begin
          if (arm_s != arm_seen) begin
            arm_seen  <= arm_s;
            wp_fell   <= !wp_s;
            sys_state <= SYS_ARMED;
          end
        end
        SYS_ARMED: begin
          if (!wp_s)
            wp_fell <= 1'b1;
          if (cs_s && stat_refused) begin
            result_ok <= 1'b0;
            done_tog  <= ~done_tog;
            sys_state <= SYS_IDLE;
          end else if (cs_s) begin
            o_cycle_busy <= 1'b1;
            sys_state    <= SYS_RUN;
          end
        end
        SYS_RUN: begin
          if (timer_done) begin
            result_ok    <= 1'b1;
            done_tog     <= ~done_tog;
            o_cycle_busy <= 1'b0;
            sys_state    <= SYS_IDLE;
          end
        end
        default: sys_state <= SYS_IDLE;
      endcase
    end
  end

  sfc_cycle_timer #(
    .WIDTH (32)
  ) u_timer (
    .i_clock  (i_clock),
    .i_rst    (i_rst),
    .i_start  (timer_start),
    .i_cycles (run_cycles),
    .o_done   (timer_done)
  );

endmodule : sfc_front_end

// ==== logic/sfc_pkg.sv ====
package sfc_pkg;

  // op-codes; bit 3 of every op-code is a don't-care
  localparam logic [7:0] SET_WRITE_LATCH_CMD   = 8'h06;
  localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD       = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD      = 8'h01;
  localparam logic [7:0] ARRAY_READ_CMD        = 8'h03;
  localparam logic [7:0] ARRAY_PROGRAM_CMD     = 8'h02;
  localparam logic [7:0] SECTOR_ERASE_CMD      = 8'h52;
  localparam logic [7:0] CHIP_ERASE_CMD        = 8'h62;
  localparam logic [7:0] IDENTITY_READ_CMD     = 8'h15;

  // status_protect_reg layout
  localparam int         READY_BIT              = 0;
  localparam int         WRITE_LATCH_BIT        = 1;
  localparam int         BLOCK_PROTECT_LO_BIT   = 2;
  localparam int         BLOCK_PROTECT_HI_BIT   = 3;
  localparam int         PROTECT_PIN_ENABLE_BIT = 7;
  localparam logic [7:0] STATUS_BUSY_VALUE      = 8'hff;
  localparam logic [1:0] BLOCK_PROTECT_RESET    = 2'h0;
  localparam logic       PIN_ENABLE_RESET       = 1'h0;

  // address layout: 24 address bits sent, sector index in bits 16:15
  localparam int         ADDR_BYTES  = 3;
  localparam int         SECTOR_MSB  = 16;
  localparam int         SECTOR_LSB  = 15;
  localparam logic [8:0] PAGE_BYTES  = 9'h100;
  localparam int         CHIP_SECTORS = 4;

  // self-timed cycles, longest times, rounded down to whole clock cycles
  localparam int CLOCK_PERIOD_NS       = 100;
  localparam int SECTOR_CLEAR_TIME_NS  = 1100000000;
  localparam int STATUS_WRITE_TIME_NS  = 60000000;
  localparam int BYTE_PROGRAM_TIME_NS  = 60000;
  localparam int SECTOR_CLEAR_CYCLES   = SECTOR_CLEAR_TIME_NS / CLOCK_PERIOD_NS;
  localparam int STATUS_WRITE_CYCLES   = STATUS_WRITE_TIME_NS / CLOCK_PERIOD_NS;
  localparam int BYTE_PROGRAM_CYCLES   = BYTE_PROGRAM_TIME_NS / CLOCK_PERIOD_NS;

  typedef enum logic [1:0] {
    KIND_STATUS  = 2'b00,
    KIND_PROGRAM = 2'b01,
    KIND_SECTOR  = 2'b10,
    KIND_CHIP    = 2'b11
  } sfc_kind_t;

  typedef enum logic [2:0] {
    FR_OPCODE  = 3'b000,
    FR_ADDRESS = 3'b001,
    FR_DATA_IN = 3'b010,
    FR_SEND    = 3'b011,
    FR_IGNORE  = 3'b100
  } sfc_frame_t;

  typedef enum logic [1:0] {
    SYS_IDLE  = 2'b00,
    SYS_ARMED = 2'b01,
    SYS_RUN   = 2'b10
  } sfc_sys_t;

endpackage : sfc_pkg

// ==== logic/sfc_sync.sv ====
`timescale 1ns/100ps
// two-stage synchroniser; each bit is an independent level or toggle
module sfc_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      meta   <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule : sfc_sync

// ==== logic/sfc_cycle_timer.sv ====
`timescale 1ns/100ps
// counts a loaded number of clock cycles, then pulses o_done once
module sfc_cycle_timer #(
  parameter int WIDTH = 32
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_start,
  input  wire logic [WIDTH-1:0] i_cycles,
  output logic                  o_done
);
  logic [WIDTH-1:0] remain;
  logic             running;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      remain  <= '0;
      running <= 1'b0;
      o_done  <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        remain  <= i_cycles;
        running <= 1'b1;
      end else if (running) begin
        remain <= remain - 1'b1;
        if (remain <= 1) begin
          running <= 1'b0;
          o_done  <= 1'b1;
        end
      end
    end
  end
endmodule : sfc_cycle_timer

// ==== sim/sfc_front_end_monitor.sv ====
`timescale 1ns/100ps
module sfc_front_end_monitor
  import sfc_pkg::*;
#(
  parameter int SECTOR_CLEAR_CYCLES_P = 50,
  parameter int STATUS_WRITE_CYCLES_P = 40,
  parameter int ADDR_WIDTH            = 17
) (
  input wire logic                  i_clock,
  input wire logic                  i_rst,
  input wire logic                  i_sck,
  input wire logic                  i_cs_n,
  input wire logic                  i_si,
  input wire logic                  i_hold_n,
  input wire logic                  i_wp_n,
  input wire logic [7:0]            i_array_data,
  input wire logic                  o_so,
  input wire logic                  o_so_oe,
  input wire logic [ADDR_WIDTH-1:0] o_array_addr,
  input wire logic                  o_cycle_busy
);
  // bound covers a full page program plus a whole-chip erase
  localparam int BUSY_MAX = 256 * BYTE_PROGRAM_CYCLES + 4 * SECTOR_CLEAR_CYCLES_P;
  logic [3:0]  rise_cnt;
  logic        so_at_rise;
  logic [31:0] busy_cnt;
  // paused rises carry no bit, so they are not counted
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) rise_cnt <= 4'h0;
    else if (i_hold_n && rise_cnt != 4'h8) rise_cnt <= rise_cnt + 4'h1;
  end
  always_ff @(posedge i_sck) so_at_rise <= o_so;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) busy_cnt <= 32'h0;
    else if (o_cycle_busy) busy_cnt <= busy_cnt + 32'h1;
    else busy_cnt <= 32'h0;
  end
  cs_idle_quiet_a: assert property (@(posedge i_clock) disable iff (i_rst)
    i_cs_n |-> !o_so_oe) else $error("output driven while deselected");
  pause_quiet_a: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_hold_n |-> !o_so_oe) else $error("output driven while paused");
  opcode_first_a: assert property (@(posedge i_sck) disable iff (i_rst)
    o_so_oe |-> rise_cnt == 4'h8) else $error("output before op-code byte ended");
  so_settled_a: assert property (@(negedge i_sck) disable iff (i_rst || i_cs_n)
    o_so_oe |-> o_so == so_at_rise) else $error("serial output moved while clock high");
  // the host may open the next frame as soon as busy shows, so look one and two edges back
  busy_after_cs_a: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(o_cycle_busy) |-> $past(i_cs_n, 1) && $past(i_cs_n, 2))
    else $error("cycle began inside a frame");
  busy_min_len_a: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(o_cycle_busy) |=> o_cycle_busy [*8]) else $error("cycle too short");
  busy_bounded_a: assert property (@(posedge i_clock) disable iff (i_rst)
    busy_cnt <= BUSY_MAX) else $error("cycle overran longest time");
  reset_release_a: assert property (@(posedge i_clock) disable iff (i_rst)
    $fell(i_rst) |-> !o_cycle_busy && !o_so_oe && o_array_addr == '0)
    else $error("outputs not idle after reset");
endmodule : sfc_front_end_monitor

bind sfc_front_end sfc_front_end_monitor #(
  .SECTOR_CLEAR_CYCLES_P(SECTOR_CLEAR_CYCLES_P),
  .STATUS_WRITE_CYCLES_P(STATUS_WRITE_CYCLES_P),
  .ADDR_WIDTH(ADDR_WIDTH)
) u_mon (.i_clock(i_clock), .i_rst(i_rst), .i_sck(i_sck), .i_cs_n(i_cs_n), .i_si(i_si),
  .i_hold_n(i_hold_n), .i_wp_n(i_wp_n), .i_array_data(i_array_data), .o_so(o_so),
  .o_so_oe(o_so_oe), .o_array_addr(o_array_addr), .o_cycle_busy(o_cycle_busy));

// ==== sim/sfc_host_model.sv ====
`timescale 1ns/100ps
// spi mode 0 master; clock stands low between frames
module sfc_host_model (
  output logic     o_sck,
  output logic     o_cs_n,
  output logic     o_si,
  output logic     o_hold_n,
  input wire logic i_so,
  input wire logic i_so_oe
);
  logic [7:0] txq [8];
  logic [7:0] rxq [8];
  int         hold_at = -1;
  logic       oe_seen;
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
    o_hold_n = 1'b1;
  end
  task automatic run(input int n);
    int b;
    oe_seen = 1'b0;
    o_cs_n = 1'b0;
    #20;
    for (b = 0; b < n * 8; b++) begin
      if (b == hold_at) begin
        o_hold_n = 1'b0;
        repeat (2) begin
          o_si = ~o_si;
          #16 o_sck = 1'b1;
          #16 o_sck = 1'b0;
        end
        o_hold_n = 1'b1;
      end
      o_si = txq[b / 8][7 - b % 8];
      #16 o_sck = 1'b1;
      rxq[b / 8][7 - b % 8] = i_so_oe ? i_so : 1'bx;
      oe_seen = oe_seen | i_so_oe;
      #16 o_sck = 1'b0;
    end
    #10 o_cs_n = 1'b1;
    // a released line must not look like a held bit
    o_si = ~o_si;
    #40;
  endtask : run
endmodule : sfc_host_model

// ==== sim/sfc_front_end_tb.sv ====
`timescale 1ns/100ps
module sfc_front_end_tb;
  import sfc_pkg::*;
  localparam int         SW    = 40;
  localparam int         SE    = 50;
  localparam logic [7:0] MAKER = 8'h3e;  // arbitrary value
  localparam logic [7:0] PART  = 8'hc1;  // arbitrary value
  logic        i_clock, i_rst, i_wp_n, sck, cs_n, si, hold_n, so, so_oe, busy;
  logic [16:0] addr;
  logic [7:0]  adata;
  int          err_total, num_checks, ticks;
  assign adata = addr[7:0] ^ 8'h3c;
  sfc_front_end #(.SECTOR_CLEAR_CYCLES_P(SE), .STATUS_WRITE_CYCLES_P(SW), .ADDR_WIDTH(17),
    .MAKER_CODE(MAKER), .PART_CODE(PART)) DUT (.i_clock(i_clock), .i_rst(i_rst), .i_sck(sck),
    .i_cs_n(cs_n), .i_si(si), .i_hold_n(hold_n), .i_wp_n(i_wp_n), .i_array_data(adata),
    .o_so(so), .o_so_oe(so_oe), .o_array_addr(addr), .o_cycle_busy(busy));
  sfc_host_model u_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .o_hold_n(hold_n),
    .i_so(so), .i_so_oe(so_oe));
  initial i_clock = 1'b0;
  always #50 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      err_total = err_total + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic xfer(input int n, input logic [47:0] bytes);
    for (int i = 0; i < 6; i++) u_host.txq[i] = bytes[47 - 8 * i -: 8];
    u_host.run(n);
  endtask : xfer
  task automatic status_read_cmd(input logic [7:0] exp);
    xfer(3, {STATUS_READ_CMD, 40'h0});
    check("status byte", u_host.rxq[2], exp);
  endtask : status_read_cmd
  task automatic wsr(input logic [7:0] v);
    xfer(1, {SET_WRITE_LATCH_CMD, 40'h0});
    xfer(2, {STATUS_WRITE_CMD, v, 32'h0});
  endtask : wsr
  // waits for a self-timed cycle; len 0 means it must not start
  task automatic cycle(input int len, input logic drop_wp, input logic [7:0] mid_op);
    int  n;
    time t0;
    n = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(negedge i_clock);
      n++;
    end
    if (len == 0) begin
      check("no cycle", busy, 8'h0);
      return;
    end
    t0 = $time;
    if (drop_wp) i_wp_n = 1'b0;
    status_read_cmd(STATUS_BUSY_VALUE);
    if (mid_op != 8'h0) xfer(1, {mid_op, 40'h0});
    n = 0;
    while (busy !== 1'b0 && n < len + 50) begin
      @(negedge i_clock);
      n++;
    end
    n = int'(($time - t0) / 100);
    check("cycle length", n >= len && n <= len + 1, 8'h1);
  endtask : cycle
  task automatic t_reset();
    check("idle oe", so_oe, 8'h0);
    status_read_cmd(8'h00);
    xfer(2, {STATUS_WRITE_CMD, 8'h8c, 32'h0});
    cycle(0, 1'b0, 8'h0);
  endtask : t_reset
  task automatic t_latch();
    xfer(1, {8'h0e, 40'h0});
    status_read_cmd(8'h02);
    @(negedge i_clock) i_wp_n = 1'b0;
    xfer(1, {8'h0c, 40'h0});
    status_read_cmd(8'h00);
    @(negedge i_clock) i_wp_n = 1'b1;
  endtask : t_latch
  task automatic t_status();
    wsr(8'h8c);
    cycle(SW, 1'b0, 8'h0);
    status_read_cmd(8'h8c);
    @(negedge i_clock) i_wp_n = 1'b0;
    wsr(8'h00);
    cycle(0, 1'b0, 8'h0);
    status_read_cmd(8'h8e);
    @(negedge i_clock) i_wp_n = 1'b1;
    fork
      xfer(2, {STATUS_WRITE_CMD, 40'h0});
      begin
        repeat (3) @(negedge i_clock);
        i_wp_n = 1'b0;
      end
    join
    cycle(0, 1'b0, 8'h0);
    @(negedge i_clock) i_wp_n = 1'b1;
    xfer(2, {STATUS_WRITE_CMD, 40'h0});
    cycle(SW, 1'b1, 8'h0);
    status_read_cmd(8'h00);
    wsr(8'h04);
    cycle(SW, 1'b0, 8'h0);
    status_read_cmd(8'h04);
  endtask : t_status
  task automatic t_writes();
    xfer(1, {SET_WRITE_LATCH_CMD, 40'h0});
    xfer(4, {SECTOR_ERASE_CMD, 24'h018000, 16'h0});
    cycle(0, 1'b0, 8'h0);
    xfer(4, {SECTOR_ERASE_CMD, 24'h010000, 16'h0});
    // erase keeps the latch set, so a clear taken during the cycle would show afterwards
    cycle(SE, 1'b0, CLEAR_WRITE_LATCH_CMD);
    status_read_cmd(8'h06);
    xfer(5, {ARRAY_PROGRAM_CMD, 24'h018000, 8'haa, 8'h0});
    cycle(0, 1'b0, 8'h0);
    xfer(6, {ARRAY_PROGRAM_CMD, 24'h000000, 16'haabb});
    cycle(2 * BYTE_PROGRAM_CYCLES, 1'b0, SET_WRITE_LATCH_CMD);
    status_read_cmd(8'h04);
    xfer(1, {SET_WRITE_LATCH_CMD, 40'h0});
    xfer(1, {CHIP_ERASE_CMD, 40'h0});
    cycle(0, 1'b0, 8'h0);
    wsr(8'h00);
    cycle(SW, 1'b0, 8'h0);
    xfer(1, {SET_WRITE_LATCH_CMD, 40'h0});
    xfer(1, {CHIP_ERASE_CMD, 40'h0});
    cycle(4 * SE, 1'b0, 8'h0);
    status_read_cmd(8'h02);
  endtask : t_writes
  task automatic t_reads();
    xfer(3, {IDENTITY_READ_CMD, 40'h0});
    check("maker code", u_host.rxq[1], MAKER);
    check("part code", u_host.rxq[2], PART);
    xfer(6, {ARRAY_READ_CMD, 24'h000010, 16'h0});
    check("array byte 0", u_host.rxq[4], 8'h10 ^ 8'h3c);
    check("array byte 1", u_host.rxq[5], 8'h11 ^ 8'h3c);
    xfer(3, {8'hff, CLEAR_WRITE_LATCH_CMD, STATUS_READ_CMD, 24'h0});
    check("oe after bad op-code", u_host.oe_seen, 8'h0);
    status_read_cmd(8'h02);
    u_host.hold_at = 4;
    status_read_cmd(8'h02);
    u_host.hold_at = 13;
    status_read_cmd(8'h02);
    u_host.hold_at = -1;
  endtask : t_reads
  initial begin
    err_total = 0;
    num_checks = 0;
    ticks = 0;
    i_rst = 1'b1;
    i_wp_n = 1'b1;
    repeat (6) @(negedge i_clock);
    i_rst = 1'b0;
    @(negedge i_clock);
    t_reset();
    t_latch();
    t_status();
    t_writes();
    t_reads();
    stop_test();
  end
endmodule : sfc_front_end_tb
